// ==== rtl/prpd_pkg.sv ====
// Shared constants and types for the password, reset and power-down command block.
package prpd_pkg;
  // Opcodes taken from the serial data lines.
  localparam logic [7:0] OPC_UNLOCK = 8'hea;
  localparam logic [7:0] OPC_ARM = 8'h66;
  localparam logic [7:0] OPC_EXEC = 8'h99;
  localparam logic [7:0] OPC_MBR = 8'hff;
  localparam logic [7:0] OPC_SLEEP = 8'hb9;
  localparam logic [7:0] OPC_WAKE = 8'hab;
  localparam logic [7:0] OPC_CLR = 8'h30;
  // Bit boundaries of the frames, counted from chip select falling.
  localparam logic [9:0] OPC_BITS = 10'h008;
  localparam logic [9:0] UNLOCK_BITS = 10'h048;
  localparam logic [9:0] ID_START = 10'h020;
  localparam logic [9:0] ID_END = 10'h028;
  localparam logic [7:0] MBR_EDGES = 8'h08;
  // Output enables, low while driving; single mode drives IO1 only.
  localparam logic [3:0] OE_SINGLE = 4'hd;
  localparam logic [3:0] OE_QUAD = 4'h0;
  localparam logic [3:0] OE_OFF = 4'hf;
  // Core clock rate and the timed intervals in nanoseconds.
  localparam int CLK_MHZ = 200;
  localparam int UNLOCK_TIME_NS = 1000;
  localparam int SW_REINIT_TIME_NS = 30000;
  localparam int POWER_UP_TIME_NS = 300000;
  localparam int SLEEP_ENTRY_TIME_NS = 3000;
  localparam int WAKE_TIME_NS = 3000;
  localparam int TMR_W = 20;
  // Frame summary captured while chip select is low.
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] edges;
    logic ones;
  } prpd_frame_t;
  // Command engine states, Gray coded along the usual path.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_UNLOCK = 3'h1,
    ST_STUCK = 3'h3,
    ST_RESET = 3'h2,
    ST_SLEEP_ENTER = 3'h6,
    ST_SLEEP = 3'h7,
    ST_WAKE = 3'h5
  } prpd_state_t;
endpackage

// ==== rtl/prpd_top.sv ====
// Password unlock, software reset, mode-bit reset, deep power-down and ID read commands.
//
// Functional notes
// - Unlock runs only if CS rises at bit 72.
// - Unlock is self-timed with busy flag held.
// - Wrong password sets error, busy stays set.
// - Clear, software or hardware reset end the error.
// - Matching password sets the protection lock.
// - Quad mode takes unlock frame four bits per clock.
// - Software reset reloads volatile state from defaults.
// - Software reset keeps both lock bits.
// - Power-on or hardware reset restores both locks.
// - Arm then execute resets after recovery time.
// - Any other command outside deep sleep cancels the armed reset.
// - Incomplete power-on makes reset take power-up time.
// - Eight ones on IO0 leave continuous read.
// - Sleep opcode exactly eight bits enters deep sleep.
// - Asleep, only wake/ID opcode is recognised.
// - Hardware reset while asleep runs power-on reset.
// - Wake opcode wakes after wake time.
// - ID follows three dummy bytes, MSB first.
// - Wake/ID ignored while a cycle is busy.
// - Quad mode takes opcodes and returns ID on four lines.
// - Single mode samples IO0 on clock rising edges.
`timescale 1ns/1ps
`default_nettype none
module prpd_top #(
  parameter logic [7:0] DEVICE_ID = 8'h5a, // Arbitrary identification value.
  parameter int UNLOCK_CYC = (prpd_pkg::UNLOCK_TIME_NS * prpd_pkg::CLK_MHZ + 999) / 1000,
  parameter int REINIT_CYC = (prpd_pkg::SW_REINIT_TIME_NS * prpd_pkg::CLK_MHZ + 999) / 1000,
  parameter int POWER_UP_CYC = (prpd_pkg::POWER_UP_TIME_NS * prpd_pkg::CLK_MHZ + 999) / 1000,
  parameter int SLEEP_CYC = prpd_pkg::SLEEP_ENTRY_TIME_NS * prpd_pkg::CLK_MHZ / 1000,
  parameter int WAKE_CYC = prpd_pkg::WAKE_TIME_NS * prpd_pkg::CLK_MHZ / 1000
) (
  input wire logic CORE_CLK, // Core clock, 200 MHz.
  input wire logic SRST, // Synchronous reset, active high; acts as power-on.
  input wire logic CS_N, // Chip select pin, active low.
  input wire logic SCK, // Serial clock pin.
  input wire logic [3:0] IO_IN, // Data pins as seen on the wires.
  output logic [3:0] IO_OUT, // Data driven onto the pins.
  output logic [3:0] IO_OE_N, // Pin drive enables, low while driving.
  input wire logic HW_RESET_N, // Hardware reset pin, active low.
  input wire logic QUAD_COMMAND_MODE, // Four-line command mode selected.
  input wire logic [63:0] STORED_PASSWORD, // Hidden password.
  input wire logic PROT_LOCK_POR_VALUE, // Power-on value of the protection lock.
  input wire logic POR_INCOMPLETE, // Earlier power-on sequence did not finish.
  input wire logic STATUS_PROTECT_SET, // Pulse: other logic sets the protect lock.
  input wire logic CONT_READ_ENTER, // Pulse: a read entered continuous mode.
  output logic OP_IN_PROGRESS_FLAG, // Self-timed operation running.
  output logic PROGRAM_ERROR_FLAG, // Password mismatch reported.
  output logic PROTECTION_LOCK_BIT, // Volatile protection lock.
  output logic STATUS_PROTECT_LOCK_BIT, // Volatile status-protect lock.
  output logic CONT_READ_MODE, // Continuous read mode active.
  output logic DEEP_SLEEP, // Deep power-down state reached.
  output logic REINIT_BUSY // Reset or power-up sequence running.
);

  ////////////////////////////////////////////////////////////////////////////////
  // Elaboration checks and helpers.

  // Every timed interval must last a cycle; the reset and power-up intervals must fit the shared timer.
  if (UNLOCK_CYC < 1 || REINIT_CYC < 1 || POWER_UP_CYC < 1 || SLEEP_CYC < 1 ||
      WAKE_CYC < 1 || POWER_UP_CYC >= (1 << prpd_pkg::TMR_W) ||
      REINIT_CYC >= (1 << prpd_pkg::TMR_W)) begin : g_bad_time
    $error("Timed interval out of range for the timer.");
  end

  // Password bytes arrive least significant first, so reverse the byte order.
  function automatic logic [63:0] swap_bytes(input logic [63:0] v);
    logic [63:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i*8 +: 8] = v[(7-i)*8 +: 8];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.

  logic [8:0] pin_s1_reg; // First stage, read only by the second stage.
  logic [8:0] pin_s2_reg; // Second stage, safe to use.
  logic [1:0] pin_s3_reg; // Delayed chip select and clock for edges.
  logic cs_low; // Chip select asserted.
  logic cs_fall; // Frame start.
  logic cs_rise; // Frame end.
  logic sck_rise; // Serial clock rising edge.
  logic sck_fall; // Serial clock falling edge.
  logic [3:0] io_s; // Synchronised data lines.
  logic hw_rst; // Synchronised hardware reset request.

  // Two flip-flops on every pin before any logic reads it.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      pin_s1_reg <= 9'h1ff;
      pin_s2_reg <= 9'h1ff;
      pin_s3_reg <= 2'h3;
    end else begin
      pin_s1_reg <= {HW_RESET_N, CS_N, SCK, 2'h3, IO_IN};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg[7:6];
    end
  end

  assign cs_low = !pin_s2_reg[7];
  assign cs_fall = !pin_s2_reg[7] && pin_s3_reg[1];
  assign cs_rise = pin_s2_reg[7] && !pin_s3_reg[1];
  assign sck_rise = pin_s2_reg[6] && !pin_s3_reg[0] && cs_low;
  assign sck_fall = !pin_s2_reg[6] && pin_s3_reg[0] && cs_low;
  assign io_s = pin_s2_reg[3:0];
  assign hw_rst = !pin_s2_reg[8];

  ////////////////////////////////////////////////////////////////////////////////
  // Frame capture.

  prpd_pkg::prpd_frame_t frame_reg; // Opcode, clock count and all-ones flag.
  logic [71:0] shift_reg; // Every bit received in this frame.
  logic [9:0] nbits; // Bits received so far.
  logic [63:0] rx_password; // Password in natural byte order.

  assign nbits = QUAD_COMMAND_MODE ? {frame_reg.edges, 2'h0} : {2'h0, frame_reg.edges};
  assign rx_password = swap_bytes(shift_reg[63:0]);

  // Count clocks since chip select fell and shift data on rising edges.
  always_ff @(posedge CORE_CLK) begin
    if (SRST || cs_fall) begin
      frame_reg <= '{opcode: 8'h00, edges: 8'h00, ones: 1'b1};
      shift_reg <= '0;
    end else if (sck_rise) begin
      if (frame_reg.edges != 8'hff) begin
        frame_reg.edges <= frame_reg.edges + 8'h01;
      end
      frame_reg.ones <= frame_reg.ones && io_s[0];
      if (QUAD_COMMAND_MODE) begin
        shift_reg <= {shift_reg[67:0], io_s};
      end else begin
        shift_reg <= {shift_reg[70:0], io_s[0]};
      end
      // The opcode is the first eight bits, whatever the width.
      if (QUAD_COMMAND_MODE && frame_reg.edges == 8'h01) begin
        frame_reg.opcode <= {shift_reg[3:0], io_s};
      end else if (!QUAD_COMMAND_MODE && frame_reg.edges == 8'h07) begin
        frame_reg.opcode <= {shift_reg[6:0], io_s[0]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode at the end of a frame.

  prpd_pkg::prpd_state_t state_reg; // Command engine state.
  logic armed_reg; // Software reset armed.
  logic cont_read_reg; // Continuous read mode.
  logic opc_done; // Full opcode seen.
  logic commit; // Frame closed with a complete opcode.
  logic fire_unlock; // Valid unlock frame.
  logic fire_exec; // Armed execute frame.
  logic fire_sleep; // Valid deep-sleep frame.
  logic fire_wake; // Wake frame while asleep.
  logic fire_clr; // Clear status frame.
  logic fire_mbr; // Mode-bit reset frame.
  logic idle; // Engine ready for commands.

  assign opc_done = nbits >= prpd_pkg::OPC_BITS;
  assign commit = cs_rise && opc_done && !cont_read_reg;
  assign idle = state_reg == prpd_pkg::ST_IDLE;
  assign fire_unlock = commit && idle && frame_reg.opcode == prpd_pkg::OPC_UNLOCK &&
                       nbits == prpd_pkg::UNLOCK_BITS;
  assign fire_exec = commit && armed_reg && frame_reg.opcode == prpd_pkg::OPC_EXEC &&
                     nbits == prpd_pkg::OPC_BITS && state_reg != prpd_pkg::ST_SLEEP &&
                     state_reg != prpd_pkg::ST_RESET;
  assign fire_sleep = commit && idle && frame_reg.opcode == prpd_pkg::OPC_SLEEP &&
                      nbits == prpd_pkg::OPC_BITS;
  assign fire_wake = commit && state_reg == prpd_pkg::ST_SLEEP &&
                     frame_reg.opcode == prpd_pkg::OPC_WAKE;
  assign fire_clr = commit && (idle || state_reg == prpd_pkg::ST_STUCK) &&
                    frame_reg.opcode == prpd_pkg::OPC_CLR && nbits == prpd_pkg::OPC_BITS;
  assign fire_mbr = cs_rise && frame_reg.ones && frame_reg.edges == prpd_pkg::MBR_EDGES;

  // Arm on the arm opcode; any other complete command outside deep sleep disarms.
  always_ff @(posedge CORE_CLK) begin
    if (SRST || hw_rst) begin
      armed_reg <= 1'b0;
    end else if (commit && state_reg != prpd_pkg::ST_SLEEP) begin
      armed_reg <= frame_reg.opcode == prpd_pkg::OPC_ARM &&
                   nbits == prpd_pkg::OPC_BITS;
    end
  end

  // Continuous read mode is left only by the mode-bit reset or a reset.
  always_ff @(posedge CORE_CLK) begin
    if (SRST || hw_rst || fire_exec) begin
      cont_read_reg <= 1'b0;
    end else if (fire_mbr) begin
      cont_read_reg <= 1'b0;
    end else if (CONT_READ_ENTER && idle) begin
      cont_read_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command engine with its shared timer.

  logic [prpd_pkg::TMR_W-1:0] timer_reg; // Cycles left in the timed state.
  logic full_reset_reg; // Running reset restores the locks too.
  logic prog_err_reg; // Password mismatch error.
  logic prot_lock_reg; // Protection lock.
  logic sp_lock_reg; // Status-protect lock.
  logic tdone; // Timer expired.

  assign tdone = timer_reg == '0;

  // State sequencing; a hardware reset outranks everything.
  always_ff @(posedge CORE_CLK) begin
    if (SRST || hw_rst) begin
      state_reg <= prpd_pkg::ST_RESET;
      timer_reg <= prpd_pkg::TMR_W'(POWER_UP_CYC - 1);
      full_reset_reg <= 1'b1;
    end else if (fire_exec) begin
      state_reg <= prpd_pkg::ST_RESET;
      full_reset_reg <= 1'b0;
      if (POR_INCOMPLETE) begin
        timer_reg <= prpd_pkg::TMR_W'(POWER_UP_CYC - 1);
      end else begin
        timer_reg <= prpd_pkg::TMR_W'(REINIT_CYC - 1);
      end
    end else begin
      if (!tdone) begin
        timer_reg <= timer_reg - 1'b1;
      end
      unique case (state_reg)
        prpd_pkg::ST_IDLE: begin
          if (fire_unlock) begin
            state_reg <= prpd_pkg::ST_UNLOCK;
            timer_reg <= prpd_pkg::TMR_W'(UNLOCK_CYC - 1);
          end else if (fire_sleep) begin
            state_reg <= prpd_pkg::ST_SLEEP_ENTER;
            timer_reg <= prpd_pkg::TMR_W'(SLEEP_CYC - 1);
          end
        end
        prpd_pkg::ST_UNLOCK: begin
          if (tdone) begin
            if (rx_password == STORED_PASSWORD) begin
              state_reg <= prpd_pkg::ST_IDLE;
            end else begin
              state_reg <= prpd_pkg::ST_STUCK;
            end
          end
        end
        prpd_pkg::ST_STUCK: begin
          if (fire_clr) begin
            state_reg <= prpd_pkg::ST_IDLE;
          end
        end
        prpd_pkg::ST_SLEEP_ENTER: begin
          if (tdone) begin
            state_reg <= prpd_pkg::ST_SLEEP;
          end
        end
        prpd_pkg::ST_SLEEP: begin
          if (fire_wake) begin
            state_reg <= prpd_pkg::ST_WAKE;
            timer_reg <= prpd_pkg::TMR_W'(WAKE_CYC - 1);
          end
        end
        prpd_pkg::ST_WAKE, prpd_pkg::ST_RESET: begin
          if (tdone) begin
            state_reg <= prpd_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg <= prpd_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Error flag: set on mismatch, cleared by clear status or any reset.
  always_ff @(posedge CORE_CLK) begin
    if (SRST || hw_rst || fire_exec) begin
      prog_err_reg <= 1'b0;
    end else if (state_reg == prpd_pkg::ST_UNLOCK && tdone &&
                 rx_password != STORED_PASSWORD) begin
      prog_err_reg <= 1'b1;
    end else if (fire_clr) begin
      prog_err_reg <= 1'b0;
    end
  end

  // Lock bits survive a software reset; a full reset restores them.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      prot_lock_reg <= 1'b0;
      sp_lock_reg <= 1'b0;
    end else if (state_reg == prpd_pkg::ST_RESET && full_reset_reg) begin
      prot_lock_reg <= PROT_LOCK_POR_VALUE;
      sp_lock_reg <= 1'b0;
    end else begin
      if (state_reg == prpd_pkg::ST_UNLOCK && tdone && rx_password == STORED_PASSWORD) begin
        prot_lock_reg <= 1'b1;
      end
      if (STATUS_PROTECT_SET) begin
        sp_lock_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Identification output on falling clock edges.

  // Drive the ID after the opcode and three dummy bytes, MSB first.
  always_ff @(posedge CORE_CLK) begin
    if (SRST || !cs_low) begin
      IO_OUT <= 4'h0;
      IO_OE_N <= prpd_pkg::OE_OFF;
    end else if (sck_fall && frame_reg.opcode == prpd_pkg::OPC_WAKE &&
                 nbits >= prpd_pkg::ID_START &&
                 (idle || state_reg == prpd_pkg::ST_SLEEP)) begin
      if (nbits >= prpd_pkg::ID_END) begin
        IO_OUT <= 4'h0;
      end else if (QUAD_COMMAND_MODE) begin
        IO_OUT <= nbits[2] ? DEVICE_ID[3:0] : DEVICE_ID[7:4];
        IO_OE_N <= prpd_pkg::OE_QUAD;
      end else begin
        IO_OUT <= {2'h0, DEVICE_ID[3'h7 - nbits[2:0]], 1'b0};
        IO_OE_N <= prpd_pkg::OE_SINGLE;
      end
    end
  end

  // Registered status outputs.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      OP_IN_PROGRESS_FLAG <= 1'b0;
      PROGRAM_ERROR_FLAG <= 1'b0;
      PROTECTION_LOCK_BIT <= 1'b0;
      STATUS_PROTECT_LOCK_BIT <= 1'b0;
      CONT_READ_MODE <= 1'b0;
      DEEP_SLEEP <= 1'b0;
      REINIT_BUSY <= 1'b1;
    end else begin
      OP_IN_PROGRESS_FLAG <= state_reg == prpd_pkg::ST_UNLOCK ||
                             state_reg == prpd_pkg::ST_STUCK;
      PROGRAM_ERROR_FLAG <= prog_err_reg;
      PROTECTION_LOCK_BIT <= prot_lock_reg;
      STATUS_PROTECT_LOCK_BIT <= sp_lock_reg;
      CONT_READ_MODE <= cont_read_reg;
      DEEP_SLEEP <= state_reg == prpd_pkg::ST_SLEEP;
      REINIT_BUSY <= state_reg == prpd_pkg::ST_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  property p_unlock_boundary;
    @(posedge CORE_CLK) disable iff (SRST || hw_rst)
    (commit && idle && frame_reg.opcode == prpd_pkg::OPC_UNLOCK &&
     nbits != prpd_pkg::UNLOCK_BITS) |=> state_reg != prpd_pkg::ST_UNLOCK;
  endproperty
  a_unlock_boundary: assert property (p_unlock_boundary)
    else $error("Unlock started on a wrong bit count.");

  property p_unlock_busy;
    @(posedge CORE_CLK) disable iff (SRST || hw_rst)
    fire_unlock |=> state_reg == prpd_pkg::ST_UNLOCK ##1 OP_IN_PROGRESS_FLAG;
  endproperty
  a_unlock_busy: assert property (p_unlock_busy)
    else $error("Unlock did not raise the busy flag.");

  property p_mismatch;
    @(posedge CORE_CLK) disable iff (SRST || hw_rst || fire_exec)
    (state_reg == prpd_pkg::ST_UNLOCK && tdone && rx_password != STORED_PASSWORD)
    |=> ##1 PROGRAM_ERROR_FLAG && OP_IN_PROGRESS_FLAG;
  endproperty
  a_mismatch: assert property (p_mismatch)
    else $error("Mismatch did not set error with busy held.");

  property p_match;
    @(posedge CORE_CLK) disable iff (SRST || hw_rst || fire_exec)
    (state_reg == prpd_pkg::ST_UNLOCK && tdone && rx_password == STORED_PASSWORD)
    |=> ##1 PROTECTION_LOCK_BIT && !OP_IN_PROGRESS_FLAG;
  endproperty
  a_match: assert property (p_match)
    else $error("Matching password did not set the lock.");

  property p_sw_keeps_locks;
    @(posedge CORE_CLK) disable iff (SRST || hw_rst)
    fire_exec |=> ##1 prot_lock_reg == $past(prot_lock_reg, 2) && !full_reset_reg;
  endproperty
  a_sw_keeps_locks: assert property (p_sw_keeps_locks)
    else $error("Software reset altered the protection lock.");

  property p_disarm;
    @(posedge CORE_CLK) disable iff (SRST || hw_rst)
    (commit && armed_reg && frame_reg.opcode != prpd_pkg::OPC_EXEC &&
     frame_reg.opcode != prpd_pkg::OPC_ARM && state_reg != prpd_pkg::ST_SLEEP)
    |=> !armed_reg;
  endproperty
  a_disarm: assert property (p_disarm)
    else $error("Armed reset survived another command.");

  property p_sleep_deaf;
    @(posedge CORE_CLK) disable iff (SRST || hw_rst)
    (state_reg == prpd_pkg::ST_SLEEP && commit && frame_reg.opcode != prpd_pkg::OPC_WAKE)
    |=> state_reg == prpd_pkg::ST_SLEEP;
  endproperty
  a_sleep_deaf: assert property (p_sleep_deaf)
    else $error("Command other than wake left deep sleep.");

  property p_sleep_entry;
    @(posedge CORE_CLK) disable iff (SRST || hw_rst || fire_exec)
    fire_sleep |=> state_reg == prpd_pkg::ST_SLEEP_ENTER ##[1:601] DEEP_SLEEP;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("Deep sleep not reached in time.");

  property p_busy_ignores_wake;
    @(posedge CORE_CLK) disable iff (SRST || hw_rst || fire_exec)
    (state_reg == prpd_pkg::ST_STUCK && commit && frame_reg.opcode == prpd_pkg::OPC_WAKE)
    |=> state_reg == prpd_pkg::ST_STUCK && prog_err_reg;
  endproperty
  a_busy_ignores_wake: assert property (p_busy_ignores_wake)
    else $error("Wake command disturbed a busy cycle.");

endmodule
`default_nettype wire

// ==== tb/prpd_host.sv ====
// Host controller model that drives command frames on the serial pins.
`timescale 1ns/1ps
`default_nettype none
module prpd_host (
  input wire logic quad,
  input wire logic [3:0] pins,
  output logic cs_n,
  output logic sck,
  output logic [3:0] io
);
  // Chip select idles high and the clock stands still outside frames.
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    io = 4'h0;
  end
  // Sends n bits MSB first, then clocks r cycles and collects the reply.
  task automatic frame(input logic [71:0] b, input int n, input int r,
    output logic [7:0] got);
    int s;
    s = quad ? 4 : 1;
    got = 8'h00;
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i -= s) begin
      io = quad ? b[i -: 4] : {~io[3:1], b[i]};
      #80 sck = 1'b1;
      #80 sck = 1'b0;
    end
    for (int j = 0; j < r; j++) begin
      io = ~io; // Released lines toggle so a stale value cannot pass.
      #80 sck = 1'b1;
      got = quad ? {got[3:0], pins} : {got[6:0], pins[1]};
      #80 sck = 1'b0;
    end
    #80 cs_n = 1'b1;
    io = ~io;
  endtask
endmodule
`default_nettype wire

// ==== tb/test_prpd_top.sv ====
// Self-checking bench for the password, reset and power-down commands.
`timescale 1ns/1ps
`default_nettype none
module test_prpd_top;
  localparam logic [63:0] PW = 64'h0123456789abcdef;
  localparam logic [7:0] DID = 8'h3c; // Arbitrary identification value.
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic hw_n = 1'b1;
  logic quad = 1'b0;
  logic sp_set = 1'b0;
  logic cr_enter = 1'b0;
  logic por_inc = 1'b0;
  logic por_val = 1'b0;
  logic cs_n, sck;
  logic [3:0] h_io, d_out, d_oe_n, pins;
  logic busy, err, lock, sp_lock, cont, sleep, rbusy;
  logic [7:0] g;
  int n_fail = 0;
  int checks = 0;
  int c, sc, lc;
  always #2.5 clk = ~clk;
  // A line shows the device where it drives and the host elsewhere.
  assign pins = (d_oe_n & h_io) | (~d_oe_n & d_out);
  prpd_host host_u (.quad(quad), .pins(pins), .cs_n(cs_n), .sck(sck), .io(h_io));
  prpd_top #(.DEVICE_ID(DID), .UNLOCK_CYC(16), .REINIT_CYC(8), .POWER_UP_CYC(16),
    .SLEEP_CYC(4), .WAKE_CYC(4)) dut_u (
    .CORE_CLK(clk), .SRST(srst), .CS_N(cs_n), .SCK(sck), .IO_IN(pins),
    .IO_OUT(d_out), .IO_OE_N(d_oe_n), .HW_RESET_N(hw_n),
    .QUAD_COMMAND_MODE(quad), .STORED_PASSWORD(PW), .PROT_LOCK_POR_VALUE(por_val),
    .POR_INCOMPLETE(por_inc), .STATUS_PROTECT_SET(sp_set),
    .CONT_READ_ENTER(cr_enter), .OP_IN_PROGRESS_FLAG(busy),
    .PROGRAM_ERROR_FLAG(err), .PROTECTION_LOCK_BIT(lock),
    .STATUS_PROTECT_LOCK_BIT(sp_lock), .CONT_READ_MODE(cont),
    .DEEP_SLEEP(sleep), .REINIT_BUSY(rbusy));
  ////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic results;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Compares one value and reports a mismatch at once.
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", w, e, s);
    end
  endtask
  // Lets n clock edges pass, then steps just past the edge.
  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Waits a bounded time for a reset sequence to end and returns its length.
  task automatic wait_rb(output int n);
    n = 0;
    while (rbusy !== 1'b0) begin
      ticks(1);
      n++;
      if (n > 2000) begin
        n_fail++;
        $display("mismatch reset wait expected 0 seen 1");
        results();
      end
    end
  endtask
  // Sends one frame and lets the commit and flag updates land.
  task automatic tx(input logic [71:0] b, input int n);
    host_u.frame(b, n, 0, g);
    ticks(10);
  endtask
  // Reorders the password so its least significant byte goes first.
  function automatic logic [63:0] swap(input logic [63:0] p);
    for (int k = 0; k < 8; k++) swap[63 - 8 * k -: 8] = p[8 * k +: 8];
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // Short, wrong, cleared and correct unlock frames.
  task automatic t_unlock;
    tx({8'hea, swap(PW)} >> 1, 71);
    chk("short unlock", 8'h00, {7'h0, busy});
    tx({8'hea, swap(PW ^ 64'h1)}, 72);
    chk("busy", 8'h01, {7'h0, busy});
    ticks(30);
    chk("error", 8'h03, {6'h0, err, busy});
    tx(72'hab, 8);
    chk("stuck on wake", 8'h03, {6'h0, err, busy});
    tx(72'h30, 8);
    chk("cleared", 8'h00, {6'h0, err, busy});
    tx({8'hea, swap(PW)}, 72);
    ticks(30);
    chk("unlocked", 8'h01, {6'h0, busy, lock});
    $display("test unlock done");
  endtask
  // Armed reset keeps the locks, a stray frame disarms, long power-up.
  task automatic t_reset;
    tx({8'hea, swap(~PW)}, 72);
    ticks(30);
    sp_set = 1'b1;
    ticks(1);
    sp_set = 1'b0;
    tx(72'h66, 8);
    tx(72'h99, 8);
    chk("reset runs", 8'h01, {7'h0, rbusy});
    wait_rb(sc);
    chk("locks kept", 8'h03, {4'h0, err, busy, sp_lock, lock});
    tx({8'hea, swap(PW)}, 72);
    ticks(30);
    chk("reissued", 8'h01, {5'h0, err, busy, lock});
    tx(72'h66, 8);
    tx(72'h30, 8);
    tx(72'h99, 8);
    chk("disarmed", 8'h00, {7'h0, rbusy});
    por_inc = 1'b1;
    tx(72'h66, 8);
    tx(72'h99, 8);
    wait_rb(lc);
    por_inc = 1'b0;
    chk("power-up length", 8'h01, {7'h0, lc > sc + 4});
    $display("test reset done");
  endtask
  // Quad sleep, ignored commands, wake, then quad and single ID reads.
  task automatic t_sleep;
    quad = 1'b1;
    tx(72'hb9, 8);
    ticks(10);
    chk("asleep", 8'h01, {7'h0, sleep});
    tx(72'h66, 8);
    tx(72'h99, 8);
    chk("ignored", 8'h02, {6'h0, sleep, rbusy});
    tx(72'hab, 8);
    ticks(10);
    chk("awake", 8'h00, {7'h0, sleep});
    host_u.frame(72'hab000000, 32, 2, g);
    chk("quad id", DID, g);
    ticks(10);
    quad = 1'b0;
    host_u.frame(72'hab000000, 32, 8, g);
    chk("id", DID, g);
    ticks(10);
    $display("test sleep done");
  endtask
  // Continuous read ignores sleep until eight ones release it.
  task automatic t_mbr;
    cr_enter = 1'b1;
    ticks(1);
    cr_enter = 1'b0;
    tx(72'hb9, 8);
    ticks(10);
    chk("read mode holds", 8'h02, {6'h0, cont, sleep});
    tx(72'hff, 8);
    chk("read mode left", 8'h00, {7'h0, cont});
    $display("test mode bits done");
  endtask
  // Hardware reset from deep sleep restores both locks.
  task automatic t_hw;
    tx(72'hb9, 8);
    ticks(10);
    // The first reset leaves deep sleep, the second restores a set lock.
    for (int v = 0; v < 2; v++) begin
      por_val = v[0];
      hw_n = 1'b0;
      ticks(4);
      hw_n = 1'b1;
      ticks(4);
      wait_rb(c);
      chk("hw reset", {7'h0, v[0]}, {5'h0, sleep, sp_lock, lock});
    end
    $display("test hardware reset done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, each scenario in turn, then the verdict.
  initial begin
    ticks(20);
    srst = 1'b0;
    wait_rb(c);
    t_unlock();
    t_reset();
    t_sleep();
    t_mbr();
    t_hw();
    results();
  end
endmodule
`default_nettype wire
